//--- rtl/sfp_pkg.sv
// Shared constants and types for the serial flash page-write sequencer
package sfp_pkg;

	// ------------------------------------------------------------
	// Serial opcodes
	// ------------------------------------------------------------
	localparam logic [7:0] OP_UNLOCK       = 8'h06;
	localparam logic [7:0] OP_STAT1_RD     = 8'h05;
	localparam logic [7:0] OP_STAT2_RD     = 8'h07;
	localparam logic [7:0] OP_PAGE_WR      = 8'h02;
	localparam logic [7:0] OP_PAGE_WR_WIDE = 8'h12;
	localparam logic [7:0] OP_QUAD_WR_A    = 8'h32;
	localparam logic [7:0] OP_QUAD_WR_B    = 8'h38;
	localparam logic [7:0] OP_QUAD_WR_WIDE = 8'h34;
	localparam logic [7:0] OP_PAUSE        = 8'h85;
	localparam logic [7:0] OP_CONTINUE     = 8'h8A;

	// ------------------------------------------------------------
	// Page geometry: 9 address bits for 512-byte pages, 8 for 256
	// ------------------------------------------------------------
	localparam int                 PAGE_AW    = 9;
	localparam int                 PAGE_BYTES = 1 << PAGE_AW;
	localparam logic [PAGE_AW-1:0] PAGE_LAST  = {PAGE_AW{1'h1}};
	localparam int                 SECTOR_AW  = 16;

	// ------------------------------------------------------------
	// Status bit positions
	// ------------------------------------------------------------
	localparam int SR1_BUSY   = 0;
	localparam int SR1_UNLOCK = 1;
	localparam int SR1_FAULT  = 6;
	localparam int SR2_PAUSED = 0;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int             CLK_MHZ   = 250;
	localparam int             BYTE_NS   = 64;
	localparam int             BYTE_CYC  = (BYTE_NS * CLK_MHZ) / 1000;
	localparam int             CNT_W     = 5;
	localparam logic [CNT_W-1:0] BYTE_LAST = CNT_W'(BYTE_CYC - 1);
	localparam int             PSL_NS    = 2000;
	localparam int             PSL_CYC   = (PSL_NS * CLK_MHZ) / 1000;

	// ------------------------------------------------------------
	// Register map (byte addresses) and reset values
	// ------------------------------------------------------------
	localparam logic [7:0] REG_CTRL  = 8'h00;
	localparam logic [7:0] REG_STAT  = 8'h04;
	localparam int         CTRL_WIDE = 0;
	localparam int         CTRL_QUAD = 1;
	localparam logic [1:0] CTRL_RST  = 2'h0;
	localparam logic [1:0] RESP_OK   = 2'h0;
	localparam logic [1:0] RESP_ERR  = 2'h2;

	// ------------------------------------------------------------
	// State types
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		SP_CMD  = 3'b000,
		SP_ADDR = 3'b001,
		SP_DATA = 3'b010,
		SP_OUT  = 3'b011,
		SP_SKIP = 3'b100
	} sfp_spi_t;

	typedef enum logic [1:0] {
		EN_IDLE = 2'b00,
		EN_RUN  = 2'b01,
		EN_SUSP = 2'b10
	} sfp_eng_t;

endpackage : sfp_pkg

//--- rtl/sfp_page_buf.sv
// Page buffer with a per-byte loaded flag
`timescale 1ns/1ns
`default_nettype none
module sfp_page_buf
	import sfp_pkg::*;
(
	input  wire logic               clk,
	input  wire logic               rst_b,
	input  wire logic               clr,
	input  wire logic               we,
	input  wire logic [PAGE_AW-1:0] widx,
	input  wire logic [7:0]         wdata,
	input  wire logic [PAGE_AW-1:0] ridx,
	output logic      [7:0]         rdata,
	output logic                    rvalid
);

	logic [7:0]            mem [PAGE_BYTES];
	logic [PAGE_BYTES-1:0] vld_q;

	// Data store; unloaded bytes are never read out as valid
	always_ff @(posedge clk) begin
		if (we) begin
			mem[widx] <= wdata;
		end
	end

	// One loaded flag per byte, cleared at each accepted program command
	generate
		for (genvar i = 0; i < PAGE_BYTES; i++) begin : g_vld
			always_ff @(posedge clk or negedge rst_b) begin
				if (!rst_b) begin
					vld_q[i] <= 1'h0;
				end else if (clr) begin
					vld_q[i] <= 1'h0;
				end else if (we && widx == PAGE_AW'(i)) begin
					vld_q[i] <= 1'h1;
				end
			end
		end
	endgenerate

	assign rdata  = mem[ridx];
	assign rvalid = vld_q[ridx];

endmodule : sfp_page_buf
`default_nettype wire

//--- rtl/sfp_prog_seq.sv
// Serial flash page-write sequencer with pause and continue
//
// How it works
// - Program commands are refused unless write unlock came first.
// - Write unlock command sets the unlock latch while the engine is idle.
// - 02h takes 3 or 4 address bytes by wide select; 12h takes 4.
// - One data byte up to one page follows the address.
// - Bytes past the page end wrap to the page start.
// - Only received bytes are written; the rest of the page stays.
// - Programming only clears bits, never sets them.
// - Busy bit reads one while programming runs, clears at end.
// - Program fault sets the fault bit.
// - Quad command captures four data bits per serial clock.
// - Quad command accepted only with quad enable and unlock latch set.
// - 32h and 38h take 3 or 4 address bytes; 34h takes 4.
// - Pause acts only while programming runs.
// - Both status reads are accepted while paused.
// - Pause flag tells paused from finished when busy falls.
// - Pause completes within the pause latency.
// - Continue is ignored unless programming is paused.
// - Valid continue sets busy again and resumes programming.
// - Second write to a 16-byte unit disables its correction code.
// - Write into an erase-paused sector fails with the fault bit.
`timescale 1ns/1ns
`default_nettype none
module sfp_prog_seq
	import sfp_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic        sck,
	input  wire logic        cs_b,
	input  wire logic [3:0]  quad_io_lines,
	output logic             so_out,
	output logic             so_oe,
	output logic [31:0]      arr_addr,
	input  wire logic [7:0]  arr_rd_data,
	input  wire logic        arr_unit_used,
	input  wire logic        arr_fault,
	output logic             arr_wr_en,
	output logic [7:0]       arr_wr_data,
	output logic             arr_ecc_off,
	input  wire logic        erase_suspended,
	input  wire logic [31:0] erase_susp_addr,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	logic       sck_s1, sck_s2, sck_s3, csb_s1, csb_s2, csb_s3;
	logic [3:0] io_s1, io_s2;

	// Two stages before use; third stage only for edge finding
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			{sck_s1, sck_s2, sck_s3} <= 3'h0;
			{csb_s1, csb_s2, csb_s3} <= 3'h7;
			io_s1                    <= 4'h0;
			io_s2                    <= 4'h0;
		end else begin
			{sck_s1, sck_s2, sck_s3} <= {sck, sck_s1, sck_s2};
			{csb_s1, csb_s2, csb_s3} <= {cs_b, csb_s1, csb_s2};
			io_s1                    <= quad_io_lines;
			io_s2                    <= io_s1;
		end
	end

	logic sck_rise, sck_fall, cs_rise;
	assign sck_rise = sck_s2 & ~sck_s3;
	assign sck_fall = ~sck_s2 & sck_s3;
	assign cs_rise  = csb_s2 & ~csb_s3;

	// ------------------------------------------------------------
	// Shared state declarations
	// ------------------------------------------------------------
	sfp_spi_t           sp_q, sp_d;
	sfp_eng_t           en_q, en_d;
	logic [2:0]         bitc_q, bitc_d, nb, step;
	logic [7:0]         sh_q, sh_d, nsh, op_q, op_d, out_q, out_d;
	logic [31:0]        addr_q, addr_d, addr_n, base_q, base_d;
	logic [1:0]         acnt_q, acnt_d, ctrl_q, ctrl_d;
	logic [PAGE_AW-1:0] widx_q, widx_d, eidx_q, eidx_d;
	logic [CNT_W-1:0]   cnt_q, cnt_d;
	logic               quad_q, quad_d, got_q, got_d, so_q, so_d, got_byte;
	logic               is_quad, is_pp, wide4, idle;
	logic               unlock_ev, pause_ev, resume_ev, start_ev, pb_clr, pb_we;
	logic               wip_q, wip_d, wel_q, wel_d, perr_q, perr_d;
	logic               psus_q, psus_d, sreq_q, sreq_d, perr_clr, ers_hit;
	logic               wr_d, ecc_d, wr_go, done;
	logic [7:0]         wdat_d, sr1, sr2, st_byte, pb_rdata;
	logic               pb_rvalid;

	// ------------------------------------------------------------
	// Status bytes
	// ------------------------------------------------------------
	always_comb begin
		sr1             = 8'h00;
		sr2             = 8'h00;
		sr1[SR1_BUSY]   = wip_q;
		sr1[SR1_UNLOCK] = wel_q;
		sr1[SR1_FAULT]  = perr_q;
		sr2[SR2_PAUSED] = psus_q;
		st_byte         = (op_q == OP_STAT2_RD) ? sr2 : sr1;
	end

	// ------------------------------------------------------------
	// Serial frame decoder
	// ------------------------------------------------------------
	assign idle     = (en_q == EN_IDLE);
	assign step     = (sp_q == SP_DATA && quad_q) ? 3'h4 : 3'h1;
	assign nb       = bitc_q + step;
	assign nsh      = (sp_q == SP_DATA && quad_q) ? {sh_q[3:0], io_s2} : {sh_q[6:0], io_s2[0]};
	assign got_byte = sck_rise && !csb_s2 && nb == 3'h0;
	assign addr_n   = {addr_q[23:0], nsh};
	assign is_quad  = nsh == OP_QUAD_WR_A || nsh == OP_QUAD_WR_B || nsh == OP_QUAD_WR_WIDE;
	assign is_pp    = nsh == OP_PAGE_WR || nsh == OP_PAGE_WR_WIDE;
	assign wide4    = nsh == OP_PAGE_WR_WIDE || nsh == OP_QUAD_WR_WIDE || ctrl_q[CTRL_WIDE];

	// Bytes are built on rising clock edges, status bits leave on falling ones
	always_comb begin
		sp_d      = sp_q;
		bitc_d    = bitc_q;
		sh_d      = sh_q;
		op_d      = op_q;
		out_d     = out_q;
		addr_d    = addr_q;
		acnt_d    = acnt_q;
		widx_d    = widx_q;
		quad_d    = quad_q;
		got_d     = got_q;
		so_d      = so_q;
		unlock_ev = 1'h0;
		pause_ev  = 1'h0;
		resume_ev = 1'h0;
		pb_clr    = 1'h0;
		pb_we     = 1'h0;
		start_ev  = cs_rise && sp_q == SP_DATA && got_q;
		if (csb_s2) begin
			sp_d   = SP_CMD;
			bitc_d = 3'h0;
		end else begin
			if (sck_rise) begin
				sh_d   = nsh;
				bitc_d = nb;
			end
			if (got_byte) begin
				case (sp_q)
					SP_CMD: begin
						op_d = nsh;
						sp_d = SP_SKIP;
						case (nsh)
							OP_UNLOCK:   unlock_ev = idle;
							OP_STAT1_RD: sp_d = SP_OUT;
							OP_STAT2_RD: sp_d = SP_OUT;
							OP_PAUSE:    pause_ev = 1'h1;
							OP_CONTINUE: resume_ev = en_q == EN_SUSP;
							default: begin
								// Locked or busy: frame ignored, nothing changes
								if ((is_pp || is_quad) && idle && wel_q
									&& (!is_quad || ctrl_q[CTRL_QUAD])) begin
									sp_d   = SP_ADDR;
									acnt_d = wide4 ? 2'h3 : 2'h2;
									addr_d = 32'h0000_0000;
									quad_d = is_quad;
									got_d  = 1'h0;
									pb_clr = 1'h1;
								end
							end
						endcase
					end
					SP_ADDR: begin
						addr_d = addr_n;
						acnt_d = acnt_q - 2'h1;
						if (acnt_q == 2'h0) begin
							sp_d   = SP_DATA;
							widx_d = addr_n[PAGE_AW-1:0];
						end
					end
					SP_DATA: begin
						pb_we  = 1'h1;
						widx_d = widx_q + 1'h1;
						got_d  = 1'h1;
					end
					default: ;
				endcase
			end
			// Status byte is refreshed every eight clocks for live polling
			if (sck_fall && sp_q == SP_OUT) begin
				if (bitc_q == 3'h0) begin
					so_d  = st_byte[7];
					out_d = {st_byte[6:0], 1'h0};
				end else begin
					so_d  = out_q[7];
					out_d = {out_q[6:0], 1'h0};
				end
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sp_q   <= SP_CMD;
			bitc_q <= 3'h0;
			sh_q   <= 8'h00;
			op_q   <= 8'h00;
			out_q  <= 8'h00;
			addr_q <= 32'h0000_0000;
			acnt_q <= 2'h0;
			widx_q <= '0;
			quad_q <= 1'h0;
			got_q  <= 1'h0;
			so_q   <= 1'h0;
		end else begin
			sp_q   <= sp_d;
			bitc_q <= bitc_d;
			sh_q   <= sh_d;
			op_q   <= op_d;
			out_q  <= out_d;
			addr_q <= addr_d;
			acnt_q <= acnt_d;
			widx_q <= widx_d;
			quad_q <= quad_d;
			got_q  <= got_d;
			so_q   <= so_d;
		end
	end

	assign so_out = so_q;
	assign so_oe  = (sp_q == SP_OUT) && !csb_s2;

	// ------------------------------------------------------------
	// Page buffer
	// ------------------------------------------------------------
	sfp_page_buf u_buf (
		.clk    (clk),
		.rst_b  (rst_b),
		.clr    (pb_clr),
		.we     (pb_we),
		.widx   (widx_q),
		.wdata  (nsh),
		.ridx   (eidx_q),
		.rdata  (pb_rdata),
		.rvalid (pb_rvalid)
	);

	// ------------------------------------------------------------
	// Program engine
	// ------------------------------------------------------------
	assign ers_hit  = erase_suspended && addr_q[31:SECTOR_AW] == erase_susp_addr[31:SECTOR_AW];
	assign arr_addr = {base_q[31:PAGE_AW], eidx_q};

	// Pause is honoured only between bytes, which bounds its latency
	always_comb begin
		en_d   = en_q;
		eidx_d = eidx_q;
		cnt_d  = cnt_q;
		base_d = base_q;
		wip_d  = wip_q;
		wel_d  = wel_q;
		perr_d = perr_q;
		psus_d = psus_q;
		sreq_d = sreq_q;
		wr_d   = 1'h0;
		ecc_d  = 1'h0;
		wdat_d = arr_wr_data;
		wr_go  = 1'h0;
		done   = 1'h0;
		if (perr_clr) begin
			perr_d = 1'h0;
		end
		if (unlock_ev) begin
			wel_d = 1'h1;
		end
		if (pause_ev && en_q == EN_RUN) begin
			sreq_d = 1'h1;
		end
		case (en_q)
			EN_IDLE: begin
				if (start_ev && ers_hit) begin
					perr_d = 1'h1;
					wel_d  = 1'h0;
				end else if (start_ev) begin
					en_d   = EN_RUN;
					wip_d  = 1'h1;
					eidx_d = '0;
					cnt_d  = '0;
					base_d = addr_q;
					psus_d = 1'h0;
				end
			end
			EN_RUN: begin
				if (sreq_q && cnt_q == '0) begin
					en_d   = EN_SUSP;
					wip_d  = 1'h0;
					psus_d = 1'h1;
					sreq_d = 1'h0;
				end else if (pb_rvalid && cnt_q != BYTE_LAST) begin
					cnt_d = cnt_q + 1'h1;
				end else begin
					wr_go  = pb_rvalid;
					cnt_d  = '0;
					eidx_d = eidx_q + 1'h1;
					if (wr_go) begin
						wr_d   = 1'h1;
						wdat_d = arr_rd_data & pb_rdata;
						ecc_d  = arr_unit_used;
						if (arr_fault) begin
							perr_d = 1'h1;
						end
					end
					done = eidx_q == PAGE_LAST || (wr_go && arr_fault);
				end
			end
			EN_SUSP: begin
				if (resume_ev) begin
					en_d   = EN_RUN;
					wip_d  = 1'h1;
					psus_d = 1'h0;
				end
			end
			default: en_d = EN_IDLE;
		endcase
		if (done) begin
			en_d   = EN_IDLE;
			wip_d  = 1'h0;
			wel_d  = 1'h0;
			psus_d = 1'h0;
			sreq_d = 1'h0;
		end
		if (perr_clr && perr_d && !perr_q) begin
			perr_d = 1'h1;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			en_q        <= EN_IDLE;
			eidx_q      <= '0;
			cnt_q       <= '0;
			base_q      <= 32'h0000_0000;
			wip_q       <= 1'h0;
			wel_q       <= 1'h0;
			perr_q      <= 1'h0;
			psus_q      <= 1'h0;
			sreq_q      <= 1'h0;
			arr_wr_en   <= 1'h0;
			arr_wr_data <= 8'h00;
			arr_ecc_off <= 1'h0;
		end else begin
			en_q        <= en_d;
			eidx_q      <= eidx_d;
			cnt_q       <= cnt_d;
			base_q      <= base_d;
			wip_q       <= wip_d;
			wel_q       <= wel_d;
			perr_q      <= perr_d;
			psus_q      <= psus_d;
			sreq_q      <= sreq_d;
			arr_wr_en   <= wr_d;
			arr_wr_data <= wdat_d;
			arr_ecc_off <= ecc_d;
		end
	end

	// ------------------------------------------------------------
	// AXI4-Lite register slave
	// ------------------------------------------------------------
	logic        awg_q, awg_d, wg_q, wg_d, bv_q, bv_d, rv_q, rv_d;
	logic [7:0]  awa_q, awa_d;
	logic [31:0] wd_q, wd_d, rd_q, rd_d;
	logic [3:0]  ws_q, ws_d;
	logic [1:0]  br_q, br_d, rr_q, rr_d;

	// Address and data are held separately so either may arrive first
	always_comb begin
		awg_d    = awg_q;
		wg_d     = wg_q;
		bv_d     = bv_q;
		rv_d     = rv_q;
		awa_d    = awa_q;
		wd_d     = wd_q;
		ws_d     = ws_q;
		rd_d     = rd_q;
		br_d     = br_q;
		rr_d     = rr_q;
		ctrl_d   = ctrl_q;
		perr_clr = 1'h0;
		if (s_axi_awvalid && !awg_q) begin
			awg_d = 1'h1;
			awa_d = s_axi_awaddr;
		end
		if (s_axi_wvalid && !wg_q) begin
			wg_d = 1'h1;
			wd_d = s_axi_wdata;
			ws_d = s_axi_wstrb;
		end
		if (bv_q && s_axi_bready) begin
			bv_d = 1'h0;
		end
		if (awg_q && wg_q && !bv_q) begin
			awg_d = 1'h0;
			wg_d  = 1'h0;
			bv_d  = 1'h1;
			br_d  = RESP_OK;
			if (awa_q == REG_CTRL) begin
				if (ws_q[0]) begin
					ctrl_d = wd_q[1:0];
				end
			end else if (awa_q == REG_STAT) begin
				perr_clr = ws_q[0] && wd_q[SR1_FAULT];
			end else begin
				br_d = RESP_ERR;
			end
		end
		if (rv_q && s_axi_rready) begin
			rv_d = 1'h0;
		end
		if (s_axi_arvalid && !rv_q) begin
			rv_d = 1'h1;
			rr_d = RESP_OK;
			if (s_axi_araddr == REG_CTRL) begin
				rd_d = {30'h0, ctrl_q};
			end else if (s_axi_araddr == REG_STAT) begin
				rd_d = {12'h000, 2'h0, en_q, sr2, sr1};
			end else begin
				rd_d = 32'h0000_0000;
				rr_d = RESP_ERR;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			awg_q  <= 1'h0;
			wg_q   <= 1'h0;
			bv_q   <= 1'h0;
			rv_q   <= 1'h0;
			awa_q  <= 8'h00;
			wd_q   <= 32'h0000_0000;
			ws_q   <= 4'h0;
			rd_q   <= 32'h0000_0000;
			br_q   <= RESP_OK;
			rr_q   <= RESP_OK;
			ctrl_q <= CTRL_RST;
		end else begin
			awg_q  <= awg_d;
			wg_q   <= wg_d;
			bv_q   <= bv_d;
			rv_q   <= rv_d;
			awa_q  <= awa_d;
			wd_q   <= wd_d;
			ws_q   <= ws_d;
			rd_q   <= rd_d;
			br_q   <= br_d;
			rr_q   <= rr_d;
			ctrl_q <= ctrl_d;
		end
	end

	assign s_axi_awready = !awg_q;
	assign s_axi_wready  = !wg_q;
	assign s_axi_bvalid  = bv_q;
	assign s_axi_bresp   = br_q;
	assign s_axi_arready = !rv_q;
	assign s_axi_rvalid  = rv_q;
	assign s_axi_rdata   = rd_q;
	assign s_axi_rresp   = rr_q;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	logic [9:0] psl_q;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			psl_q <= 10'h000;
		end else begin
			psl_q <= sreq_q ? psl_q + 10'h001 : 10'h000;
		end
	end

	// Address width registered every cycle, so the length check sees that of the accepted command
	logic wide4_q;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wide4_q <= 1'h0;
		end else begin
			wide4_q <= wide4;
		end
	end

	a_lock_start_gate: assert property (en_q == EN_IDLE && en_d == EN_RUN |-> wel_q)
		else $error("program started without unlock latch");
	a_unlock_sets: assert property (unlock_ev |=> wel_q)
		else $error("unlock latch not set");
	a_addr_len: assert property (pb_clr |=> acnt_q == (wide4_q ? 2'h3 : 2'h2))
		else $error("wrong address length");
	a_page_wrap: assert property (pb_we |=> widx_q == $past(widx_q) + 1'h1)
		else $error("buffer index did not advance");
	a_only_clear: assert property (arr_wr_en |-> (arr_wr_data & ~$past(arr_rd_data)) == 8'h00)
		else $error("write sets a bit");
	a_busy_bit: assert property (en_q == EN_RUN |-> wip_q)
		else $error("busy bit low while running");
	a_quad_nibble: assert property (sp_q == SP_DATA && quad_q && sck_rise && !csb_s2
		|=> bitc_q == $past(bitc_q) + 3'h4)
		else $error("quad capture not four bits");
	a_pause_latency: assert property (psl_q <= 10'(PSL_CYC))
		else $error("pause took too long");
	a_resume_busy: assert property (resume_ev |=> wip_q && en_q == EN_RUN && !psus_q)
		else $error("continue did not restart");
	a_pause_flag: assert property ($fell(wip_q) |-> psus_q == (en_q == EN_SUSP))
		else $error("pause flag wrong at busy fall");
	a_erase_fault: assert property (en_q == EN_IDLE && start_ev && ers_hit
		|=> perr_q && en_q == EN_IDLE)
		else $error("erase-paused sector not refused");

	c_full_run: cover property (en_q == EN_RUN ##1 en_q == EN_IDLE);
	c_pause_resume: cover property (en_q == EN_SUSP ##[1:1000] en_q == EN_RUN);
	c_quad_start: cover property (start_ev && quad_q);

endmodule : sfp_prog_seq
`default_nettype wire

//--- verif/sfp_host.sv
// Host serial controller model: drives link clock, select and data lines
`timescale 1ns/1ns
`default_nettype none
module sfp_host (
	output logic       sck,
	output logic       cs_b,
	output logic [3:0] io,
	input  wire logic  so
);
	// ----
	// Link idle state
	// ----
	initial begin
		sck = 1'h0;
		cs_b = 1'h1;
		io = 4'h0;
	end
	// Clock runs only inside a frame, 32 ns period stays under 80 MHz
	task automatic xfer(input logic [7:0] b, input bit q4, output logic [7:0] r);
		for (int i = 0; i < (q4 ? 2 : 8); i++) begin
			if (q4) io = i ? b[3:0] : b[7:4];
			else io = {~io[3:1], b[7-i]};
			#16 sck = 1'h1;
			#16 r = {r[6:0], so};
			sck = 1'h0;
		end
		io = ~io; // Released lines must not keep the last value
	endtask : xfer
	// Extra 1 ns drifts the link phase away from the system clock
	task automatic frame(input bit on);
		#17 cs_b = !on;
		#16;
	endtask : frame
endmodule : sfp_host
`default_nettype wire

//--- verif/tb.sv
// Testbench: serial page writes checked against a queue model
`timescale 1ns/1ns
`default_nettype none
module tb;
	import sfp_pkg::*;
	logic        clk, rst_b, sck, cs_b, so, wen, er, bv, rv, awr, wrr, arr, awv, wv, arv, br, rr;
	logic        soe, eco, flt, esus;
	logic [3:0]  io;
	logic [7:0]  awa, ara, wd, rb;
	logic [31:0] aa, pa, wdat, rdat;
	logic [31:0] seed = 32'h39;
	logic [1:0]  rresp, bresp, brs;
	logic [39:0] s;
	logic [39:0] q[$];
	logic [7:0]  ops[6] = '{OP_PAGE_WR, OP_PAGE_WR_WIDE, OP_QUAD_WR_A, OP_QUAD_WR_B,
		OP_QUAD_WR_WIDE, OP_PAGE_WR};
	int          n_fail, cmp_count;
	// Undriven output line reads as the inverse, so a missing enable shows up
	sfp_host host(.sck(sck), .cs_b(cs_b), .io(io), .so(soe ? so : ~so));
	// Array model: erased for quad writes, address pattern otherwise
	// Units with address bit 4 set count as already programmed
	sfp_prog_seq dut(.clk(clk), .rst_b(rst_b), .sck(sck), .cs_b(cs_b), .quad_io_lines(io),
		.so_out(so), .so_oe(soe), .arr_addr(aa), .arr_rd_data(er ? 8'hFF : aa[7:0] ^ 8'hC3),
		.arr_unit_used(aa[4]), .arr_fault(flt), .arr_wr_en(wen), .arr_wr_data(wd),
		.arr_ecc_off(eco), .erase_suspended(esus), .erase_susp_addr(32'h0),
		.s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wdat),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrr), .s_axi_bresp(bresp),
		.s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
		.s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
		.s_axi_rready(rr));
	// ----
	// Helpers
	// ----
	initial begin
		clk = 1'h0;
		forever #2 clk = ~clk;
	end
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	task automatic chk(input logic [39:0] got, input logic [39:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic wrap_up;
		if (n_fail == 0 && cmp_count > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : wrap_up
	// Bus tasks hold each channel until its own ready is seen
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bit pw, pd;
		pw = 1;
		pd = 1;
		awa <= a;
		wdat <= d;
		awv <= 1'h1;
		wv <= 1'h1;
		br <= 1'h1;
		do begin
			@(posedge clk);
			if (awr) pw = 0;
			if (wrr) pd = 0;
			awv <= pw;
			wv <= pd;
		end while (pw | pd);
		do @(posedge clk); while (bv !== 1'h1);
		brs = bresp;
		br <= 1'h0;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		ara <= a;
		arv <= 1'h1;
		rr <= 1'h1;
		do @(posedge clk); while (arr !== 1'h1);
		arv <= 1'h0;
		while (rv !== 1'h1) @(posedge clk);
		s = {6'h0, rresp, rdat}; // rready is raised by every poll and never lowered, so it stays high between polls
	endtask : rd
	task automatic idle;
		do rd(REG_STAT); while (s[0] !== 1'h0);
	endtask : idle
	task automatic cmd(input logic [7:0] op, input logic [7:0] b2, input bit two);
		host.frame(1);
		host.xfer(op, 0, rb);
		if (two) host.xfer(b2, 0, rb);
		host.frame(0);
		@(posedge clk);
	endtask : cmd
	// Start at the last page index so the data wraps whenever more than one byte is sent
	task automatic prog(input logic [7:0] op, input int nb, input int n, input bit ok);
		logic [31:0] a;
		logic [7:0]  d;
		logic [39:0] f, f0;
		a = rnd() | 32'h1FF;
		if (nb == 3) a[31:24] = 8'h0;
		if (esus) a[31:16] = 16'h0;
		er = op[5];
		host.frame(1);
		host.xfer(op, 0, rb);
		for (int i = nb - 1; i >= 0; i--) host.xfer(a[8*i +: 8], 0, rb);
		for (int k = 0; k < n; k++) begin
			d = rnd();
			host.xfer(d, er, rb);
			f = {a[31:9], 9'(a[8:0] + k), d & (er ? 8'hFF : 8'(a + k) ^ 8'hC3)};
			if (k == 0) f0 = f;
			else if (ok) q.push_back(f);
		end
		// Byte zero sits at the last index and the page is scanned from index zero
		if (ok) q.push_back(f0);
		host.frame(0);
		@(posedge clk);
	endtask : prog
	// Every array write must match the next expected byte
	always @(posedge clk) begin
		pa <= aa;
		if (wen === 1'h1) begin
			chk({pa, wd}, q.size() ? q.pop_front() : 40'h0);
			chk(eco, pa[4]);
		end
	end
	initial begin
		#200000;
		n_fail++;
		wrap_up;
	end
	// ----
	// Scenarios
	// ----
	initial begin
		{rst_b, er, flt, esus, awv, wv, arv, br, rr, awa, ara, wdat} = '0;
		repeat (4) @(posedge clk);
		rst_b <= 1'h1;
		@(posedge clk);
		rd(REG_STAT); chk(s, 40'h0);
		rd(8'h08); chk(s, {6'h0, RESP_ERR, 32'h0});
		wr(8'h08, 32'h0); chk(brs, RESP_ERR);
		prog(OP_PAGE_WR, 3, 2, 0);
		rd(REG_STAT); chk(s, 40'h0);
		cmd(OP_UNLOCK, 8'h0, 0);
		rd(REG_STAT); chk(s, 40'h2);
		prog(OP_QUAD_WR_A, 3, 2, 0);
		rd(REG_STAT); chk(s, 40'h2);
		for (int i = 0; i < 6; i++) begin
			wr(REG_CTRL, i == 5 ? 32'h3 : 32'h2);
			chk(brs, RESP_OK);
			cmd(OP_UNLOCK, 8'h0, 0);
			prog(ops[i], (i == 1 || i >= 4) ? 4 : 3, i + 1, 1);
			rd(REG_STAT); chk(s[1:0], 2'h3);
			idle;
			chk(s[1:0], 2'h0);
			chk(40'(q.size()), 40'h0);
		end
		esus <= 1'h1;
		cmd(OP_UNLOCK, 8'h0, 0);
		prog(OP_PAGE_WR_WIDE, 4, 2, 0);
		rd(REG_STAT); chk(s[7:0], 8'h40);
		{esus, flt} <= 2'h1;
		wr(REG_STAT, 32'h40);
		cmd(OP_UNLOCK, 8'h0, 0);
		prog(OP_PAGE_WR_WIDE, 4, 2, 1);
		idle;
		chk({q.size() == 1, s[7:0]}, 9'h140);
		q.delete();
		flt <= 1'h0;
		wr(REG_STAT, 32'h40);
		rd(REG_STAT); chk(s[7:0], 8'h00);
		cmd(OP_UNLOCK, 8'h0, 0);
		prog(OP_PAGE_WR, 4, 16, 1);
		cmd(OP_PAUSE, 8'h0, 0);
		repeat (PSL_CYC) @(posedge clk);
		rd(REG_STAT); chk({s[8], s[0]}, 2'h2);
		cmd(OP_STAT1_RD, 8'h0, 1); chk(rb[0], 1'h0);
		cmd(OP_STAT2_RD, 8'h0, 1); chk(rb[0], 1'h1);
		chk(soe, 1'h0);
		cmd(OP_CONTINUE, 8'h0, 0);
		rd(REG_STAT); chk({s[8], s[0]}, 2'h1);
		idle;
		chk(40'(q.size()), 40'h0);
		cmd(OP_PAUSE, 8'h0, 0);
		cmd(OP_CONTINUE, 8'h0, 0);
		rd(REG_STAT); chk(s[15:0], 16'h0);
		wrap_up;
	end
endmodule : tb
`default_nettype wire
